// File: hdl/msc_pkg.sv
// Package of constants for the modem card sideband control block.
package msc_pkg;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_FREQ_HZ       = 100_000_000;
	localparam int unsigned DEBOUNCE_TIME_US  = 10;
	localparam int unsigned DEBOUNCE_CYCLES   = DEBOUNCE_TIME_US * (CLK_FREQ_HZ / 1_000_000);
	localparam int unsigned DEB_CNT_W         = 11;
	localparam int unsigned RESET_STRETCH_CYC = 16;
	localparam int unsigned STRETCH_W         = 5;
	localparam int unsigned BOOT_TIME_CYCLES  = 64;
	localparam int unsigned BOOT_W            = 7;

	// ==========================================================
	// Status indicator patterns
	localparam logic [1:0] LED_OFF   = 2'h0;
	localparam logic [1:0] LED_ON    = 2'h1;
	localparam logic [1:0] LED_SLOW  = 2'h2;
	localparam logic [1:0] LED_FAST  = 2'h3;
	localparam int unsigned LED_DIV_W = 24;
	localparam int unsigned LED_SLOW_BIT = 23;
	localparam int unsigned LED_FAST_BIT = 21;

	// ==========================================================
	// Card software life cycle
	typedef enum logic [1:0] {
		MSC_IN_RESET,
		MSC_BOOTING,
		MSC_RUNNING
	} msc_state_t;

endpackage

// File: hdl/msc_debounce.sv
// Synchroniser and debouncer for one asynchronous active-low pin.
`timescale 1ns/1ps
module msc_debounce (
	input  wire logic clock_i,
	input  wire logic nrst_i,
	input  wire logic pin_n_i,
	output logic      level_n_o
);

	// ==========================================================
	// Synchroniser
	logic sync_a;
	logic sync_b;
	logic [msc_pkg::DEB_CNT_W-1:0] cnt;
	logic [msc_pkg::DEB_CNT_W-1:0] next_cnt;
	logic next_level_n;

	// The first stage feeds only the second stage; released pins read high.
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync_a    <= 1'b1;
			sync_b    <= 1'b1;
			cnt       <= '0;
			level_n_o <= 1'b1;
		end else begin
			sync_a    <= pin_n_i;
			sync_b    <= sync_a;
			cnt       <= next_cnt;
			level_n_o <= next_level_n;
		end
	end

	// ==========================================================
	// Debounce
	// A new level is accepted only after it held steady for the whole window.
	always_comb begin
		next_cnt     = '0;
		next_level_n = level_n_o;
		if (sync_b != level_n_o) begin
			if (cnt == msc_pkg::DEB_CNT_W'(msc_pkg::DEBOUNCE_CYCLES - 1)) begin
				next_level_n = sync_b;
			end else begin
				next_cnt = cnt + 1'b1;
			end
		end
	end

endmodule

// File: hdl/msc_sideband.sv
// Sideband control of the modem card: wake, reset, radio disable and status LED.
// Functional notes
// - Wake pin only pulled low or released, never driven high.
// - Card software sets and clears the wake request.
// - A low pulse on the reset pin resets the whole card.
// - After reset, software restarts and then sends a startup notice.
// - Reset pin pulled up internally; unconnected means run normally.
// - Radio stays off while the radio-disable pin is low.
// - Radio-disable pin pulled up; unconnected leaves the radio on.
// - Status LED output sinks current in patterns showing network state.
`timescale 1ns/1ps
module msc_sideband (
	input  wire logic       clock_i,
	input  wire logic       nrst_i,
	input  wire logic       card_reset_in_n_i,
	input  wire logic       radio_disable_n_i,
	input  wire logic       sw_wake_req_i,
	input  wire logic       notice_enable_i,
	input  wire logic [1:0] led_pattern_i,
	output logic            wake_n_o,
	output logic            wake_n_oe_o,
	output logic            card_reset_o,
	output logic            radio_enable_o,
	output logic            startup_notice_o,
	output logic            sw_running_o,
	output logic            net_status_led_n_o
);

	// ==========================================================
	// Pin conditioning
	// Both host pins arrive from outside the clock domain.
	// Each passes a two-stage synchroniser before any logic reads it.
	// A debounce window then hides glitches picked up on the slot wiring.
	// The price is latency: a real request is seen about ten microseconds late.
	// That delay is harmless for a reset or a radio shutdown.
	logic reset_level_n;
	logic radio_level_n;

	// The pins rest high when unconnected, so the filters start high.
	msc_debounce u_reset_deb (
		.clock_i   (clock_i),
		.nrst_i    (nrst_i),
		.pin_n_i   (card_reset_in_n_i),
		.level_n_o (reset_level_n)
	);

	msc_debounce u_radio_deb (
		.clock_i   (clock_i),
		.nrst_i    (nrst_i),
		.pin_n_i   (radio_disable_n_i),
		.level_n_o (radio_level_n)
	);

	// ==========================================================
	// Life cycle
	// The card passes through three phases after any reset.
	// In reset, the internal system reset is held high.
	// While booting, software is assumed to be starting up.
	// Once running, software owns the wake and indicator outputs; the radio-disable pin drives the radio.
	// A filtered reset pulse returns the card to the first phase at once.
	// The boot length is a stand-in for a real software start-up time.
	// Users must not rely on its exact value.
	msc_pkg::msc_state_t state;
	msc_pkg::msc_state_t next_state;
	logic [msc_pkg::STRETCH_W-1:0] stretch;
	logic [msc_pkg::STRETCH_W-1:0] next_stretch;
	logic [msc_pkg::BOOT_W-1:0]    boot;
	logic [msc_pkg::BOOT_W-1:0]    next_boot;
	logic                          next_card_reset;
	logic                          next_notice;
	logic                          next_running;

	// Life cycle registers; the outputs come straight from flip-flops.
	// The system reset output starts high so nothing runs before the stretch.
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state            <= msc_pkg::MSC_IN_RESET;
			stretch          <= '0;
			boot             <= '0;
			card_reset_o     <= 1'b1;
			startup_notice_o <= 1'b0;
			sw_running_o     <= 1'b0;
		end else begin
			state            <= next_state;
			stretch          <= next_stretch;
			boot             <= next_boot;
			card_reset_o     <= next_card_reset;
			startup_notice_o <= next_notice;
			sw_running_o     <= next_running;
		end
	end

	// The reset is held a little past the pulse so every block sees it.
	// A long pulse simply extends the reset; the host limits its length.
	// The startup notice is a single-cycle pulse, raised on the same edge
	// as the running flag, and only when the notice setting is on.
	// A pulse that arrives during boot restarts the whole sequence,
	// so a notice is never sent for a boot that did not finish.
	always_comb begin
		next_state      = state;
		next_stretch    = stretch;
		next_boot       = boot;
		next_card_reset = 1'b0;
		next_notice     = 1'b0;
		next_running    = 1'b0;
		if (!reset_level_n) begin
			next_state      = msc_pkg::MSC_IN_RESET;
			next_stretch    = '0;
			next_card_reset = 1'b1;
		end else begin
			case (state)
				msc_pkg::MSC_IN_RESET: begin
					next_card_reset = 1'b1;
					if (stretch == msc_pkg::STRETCH_W'(msc_pkg::RESET_STRETCH_CYC - 1)) begin
						next_state      = msc_pkg::MSC_BOOTING;
						next_boot       = '0;
						next_card_reset = 1'b0;
					end else begin
						next_stretch = stretch + 1'b1;
					end
				end
				msc_pkg::MSC_BOOTING: begin
					if (boot == msc_pkg::BOOT_W'(msc_pkg::BOOT_TIME_CYCLES - 1)) begin
						next_state   = msc_pkg::MSC_RUNNING;
						next_notice  = notice_enable_i;
						next_running = 1'b1;
					end else begin
						next_boot = boot + 1'b1;
					end
				end
				msc_pkg::MSC_RUNNING: begin
					next_running = 1'b1;
				end
				default: begin
					next_state      = msc_pkg::MSC_IN_RESET;
					next_card_reset = 1'b1;
				end
			endcase
		end
	end

	// ==========================================================
	// Wake, radio and status indicator
	// The wake pin is open drain: its data output is tied low and only
	// the enable moves, so the card can never fight the host's pull-up.
	// The radio enable follows the filtered disable pin one edge later.
	// The indicator divider runs freely; blink phase is not tied to the pattern
	// change, so the first blink after a change may be shortened.
	// That costs nothing visible and saves a restart path on the divider.
	logic [msc_pkg::LED_DIV_W-1:0] led_div;
	logic [msc_pkg::LED_DIV_W-1:0] next_led_div;
	logic                          next_wake_oe;
	logic                          next_radio;
	logic                          next_led_n;

	// Output registers; the radio is off and the indicator dark in reset.
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			led_div            <= '0;
			wake_n_oe_o        <= 1'b0;
			wake_n_o           <= 1'b0;
			radio_enable_o     <= 1'b0;
			net_status_led_n_o <= 1'b1;
		end else begin
			led_div            <= next_led_div;
			wake_n_oe_o        <= next_wake_oe;
			wake_n_o           <= 1'b0;
			radio_enable_o     <= next_radio;
			net_status_led_n_o <= next_led_n;
		end
	end

	// Outputs stay quiet while the card is held in reset or still booting.
	always_comb begin
		next_led_div = led_div + 1'b1;
		next_wake_oe = sw_wake_req_i && (state == msc_pkg::MSC_RUNNING);
		next_radio   = radio_level_n && (state == msc_pkg::MSC_RUNNING);
		next_led_n   = 1'b1;
		if (state == msc_pkg::MSC_RUNNING) begin
			case (led_pattern_i)
				msc_pkg::LED_OFF:  next_led_n = 1'b1;
				msc_pkg::LED_ON:   next_led_n = 1'b0;
				msc_pkg::LED_SLOW: next_led_n = ~led_div[msc_pkg::LED_SLOW_BIT];
				msc_pkg::LED_FAST: next_led_n = ~led_div[msc_pkg::LED_FAST_BIT];
				default:           next_led_n = 1'b1;
			endcase
		end
	end

endmodule

// File: testbench/msc_sideband_assertions.sv
// Port checker for the sideband control block.
`timescale 1ns/1ps
module msc_sideband_assertions (
	input wire logic       clock_i, nrst_i, card_reset_in_n_i, radio_disable_n_i,
	input wire logic       sw_wake_req_i, notice_enable_i,
	input wire logic [1:0] led_pattern_i,
	input wire logic       wake_n_o, wake_n_oe_o, card_reset_o, radio_enable_o,
	input wire logic       startup_notice_o, sw_running_o, net_status_led_n_o
);
	// ========
	// Low-run counters, so a glitch can never pass for a real request.
	logic [10:0] rc, dc;
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rc <= 11'h000;
			dc <= 11'h000;
		end else begin
			rc <= card_reset_in_n_i ? 11'h000 : rc + 11'(rc != 11'h7ff);
			dc <= radio_disable_n_i ? 11'h000 : dc + 11'(dc != 11'h7ff);
		end
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	chk_wake_low: assert property (wake_n_o == 1'b0) else $error("wake driven high");
	chk_wake_soft: assert property (wake_n_oe_o |-> $past(sw_wake_req_i)) else $error("wake unasked");
	chk_reset_quiet: assert property ($rose(card_reset_o) |=> !sw_running_o && !radio_enable_o)
		else $error("card runs in reset");
	chk_reset_filter: assert property ($rose(card_reset_o) |-> $past(rc, 3) >= msc_pkg::DEBOUNCE_CYCLES)
		else $error("reset on short pulse");
	chk_radio_filter: assert property ($fell(radio_enable_o) && sw_running_o |-> $past(dc, 3) >= msc_pkg::DEBOUNCE_CYCLES)
		else $error("radio off on short pulse");
	chk_radio_back: assert property ($rose(radio_enable_o) |-> sw_running_o && radio_disable_n_i)
		else $error("radio on while disabled");
	chk_notice_boot: assert property (startup_notice_o |-> $rose(sw_running_o) && $past(notice_enable_i))
		else $error("stray notice");
	chk_boot_len: assert property ($fell(card_reset_o) |-> ##[60:70] sw_running_o) else $error("boot too long");
	chk_led_lit: assert property ($past(nrst_i) && $past(sw_running_o) && $past(led_pattern_i) == msc_pkg::LED_ON |-> !net_status_led_n_o)
		else $error("led not lit");
endmodule
bind msc_sideband msc_sideband_assertions chk (.clock_i, .nrst_i, .card_reset_in_n_i, .radio_disable_n_i,
	.sw_wake_req_i, .notice_enable_i, .led_pattern_i, .wake_n_o, .wake_n_oe_o, .card_reset_o,
	.radio_enable_o, .startup_notice_o, .sw_running_o, .net_status_led_n_o);

// File: testbench/msc_host_model.sv
// Host model: wake pull-up plus the reset and radio-disable pins.
`timescale 1ns/1ps
module msc_host_model (
	input  wire logic clock_i, wake_n_i, wake_n_oe_i, sw_running_i,
	output logic      card_reset_in_n_o = 1'h1, radio_disable_n_o = 1'h1,
	output logic      wake_seen_o
);
	// The pull-up wins whenever the card lets go; a low line means wake.
	assign wake_seen_o = wake_n_oe_i ? !wake_n_i : 1'h0;
	// Pulses start just after an edge and are cut at one second.
	task automatic pulse(input bit rst, input int n);
		if (rst) wait (sw_running_i === 1'h1);
		@(posedge clock_i) #1;
		if (rst) card_reset_in_n_o = 1'h0;
		else radio_disable_n_o = 1'h0;
		repeat (n < 100_000_000 ? n : 100_000_000) @(posedge clock_i);
		#1 card_reset_in_n_o = 1'h1;
		radio_disable_n_o = 1'h1;
	endtask
endmodule

// File: testbench/msc_sideband_tb.sv
// Self-checking bench for the sideband control block.
`timescale 1ns/1ps
module msc_sideband_tb;
	logic       clock_i = 0, nrst_i = 0, req = 0, ne = 1;
	logic [1:0] pat = 2'h1;
	logic       rst_n, rad_n, oe, wn, crst, ren, ntc, run, led, seen;
	int         mismatches = 0, tests_run = 0, nseen = 0, seed = 32'hc025_ae39, i, n, k, m;
	always #5 clock_i = ~clock_i;
	always @(posedge clock_i) if (ntc === 1'h1) nseen++;
	msc_sideband dut (.clock_i, .nrst_i, .card_reset_in_n_i(rst_n), .radio_disable_n_i(rad_n),
		.sw_wake_req_i(req), .notice_enable_i(ne), .led_pattern_i(pat), .wake_n_o(wn),
		.wake_n_oe_o(oe), .card_reset_o(crst), .radio_enable_o(ren), .startup_notice_o(ntc),
		.sw_running_o(run), .net_status_led_n_o(led));
	msc_host_model host (.clock_i, .wake_n_i(wn), .wake_n_oe_i(oe), .sw_running_i(run),
		.card_reset_in_n_o(rst_n), .radio_disable_n_o(rad_n), .wake_seen_o(seen));
	// ========
	// A pin pulse only counts once it outlasts the filter.
	function automatic logic taken(int len);
		return len >= msc_pkg::DEBOUNCE_CYCLES;
	endfunction
	task automatic chk(input logic got, exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge clock_i);
		#1;
	endtask
	task automatic wait_run();
		for (k = 0; k < 3000 && run !== 1'h1; k++) tick(1);
	endtask
	task automatic finish_test();
		$display("%0d compared, %0d wrong", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		#400us;
		mismatches++;
		finish_test();
	end
	// Boot, wake and LED first; then pin pulses alternately long and short.
	initial begin
		tick(2);
		nrst_i = 1;
		wait_run();
		tick(2);
		chk(nseen == 1, 1'h1);
		for (i = 0; i < 24; i++) begin
			req = $random(seed);
			tick(1);
			chk(seen, req);
			chk(wn, 1'h0);
		end
		for (i = 0; i < 2; i++) begin
			pat = i ? msc_pkg::LED_OFF : msc_pkg::LED_ON;
			tick(2);
			chk(led, i[0]);
		end
		// Blink patterns start in their dark half, since the divider starts at zero.
		for (i = 0; i < 4; i++) begin
			pat = i[1:0];
			tick(2);
			chk(led, i != 1);
		end
		$display("wake and led test done");
		for (i = 0; i < 4; i++) begin
			n = (i[0] ? 300 : 1300) + ($random(seed) & 255);
			host.pulse(0, n);
			chk(ren, !taken(n));
			tick(1100);
			chk(ren, 1'h1);
			ne = $random(seed);
			m = nseen;
			host.pulse(1, n);
			chk(crst, taken(n));
			wait_run();
			tick(2);
			chk(nseen == m + (taken(n) & ne), 1'h1);
		end
		$display("pin pulse test done");
		m = nseen;
		nrst_i = 0;
		tick(2);
		chk(crst, 1'h1);
		nrst_i = 1;
		wait_run();
		tick(2);
		chk(nseen == m + ne, 1'h1);
		$display("mid-run reset test done");
		finish_test();
	end
endmodule
